// ### atc_pkg.sv
`default_nettype none
package atc_pkg;
  // Register indexes; each register sits at byte address four times its index.
  localparam logic [7:0] IDX_X_OFF  = 8'h33;
  localparam logic [7:0] IDX_Y_OFF  = 8'h34;
  localparam logic [7:0] IDX_Z_OFF  = 8'h35;
  localparam logic [7:0] IDX_X_GAIN = 8'h36;
  localparam logic [7:0] IDX_Y_GAIN = 8'h37;
  localparam logic [7:0] IDX_Z_GAIN = 8'h38;
  localparam logic [7:0] ADDR_X_OFF  = 8'(IDX_X_OFF << 2);
  localparam logic [7:0] ADDR_Y_OFF  = 8'(IDX_Y_OFF << 2);
  localparam logic [7:0] ADDR_Z_OFF  = 8'(IDX_Z_OFF << 2);
  localparam logic [7:0] ADDR_X_GAIN = 8'(IDX_X_GAIN << 2);
  localparam logic [7:0] ADDR_Y_GAIN = 8'(IDX_Y_GAIN << 2);
  localparam logic [7:0] ADDR_Z_GAIN = 8'(IDX_Z_GAIN << 2);
  // Field widths of the trims and of the axis samples.
  localparam int OFF_W      = 5;
  localparam int GAIN_W     = 6;
  localparam int SMP_W      = 14;
  localparam int GAIN_SHIFT = 6;
  // Reset values: no user correction.
  localparam logic [4:0] OFF_RST  = 5'h00;
  localparam logic [5:0] GAIN_RST = 6'h00;
  // Shared trim range, checked on the sum of factory and user trims.
  localparam logic signed [5:0] OFF_SUM_MAX  = 6'sh0f;
  localparam logic signed [5:0] OFF_SUM_MIN  = 6'sh30;
  localparam logic signed [6:0] GAIN_SUM_MAX = 7'sh1f;
  localparam logic signed [6:0] GAIN_SUM_MIN = 7'sh60;
  // Output sample limits.
  localparam logic signed [15:0] SMP_MAX = 16'sh1fff;
  localparam logic signed [15:0] SMP_MIN = 16'she000;
  // Output counts per offset step; plain default.
  localparam logic signed [7:0] OFF_STEP = 8'sh10;
endpackage
`default_nettype wire

// ### atc_axis_trim.sv
`timescale 1ns/1ps
`default_nettype none
module atc_axis_trim
  import atc_pkg::*;
(
  input  wire logic                     core_clk,
  input  wire logic                     sys_rst,
  input  wire logic signed [SMP_W-1:0]  sampleIn,
  input  wire logic [OFF_W-1:0]         userOffset,
  input  wire logic [GAIN_W-1:0]        userGain,
  input  wire logic [OFF_W-1:0]         factoryOffset,
  input  wire logic [GAIN_W-1:0]        factoryGain,
  output logic signed [SMP_W-1:0]       sampleOut
);
  typedef struct packed {
    logic [SMP_W-1:0] outVal;
  } atc_axis_st_t;

  atc_axis_st_t q, d;
  logic signed [OFF_W:0]   sumOff;
  logic signed [GAIN_W:0]  sumGain;
  logic signed [OFF_W:0]   satOff;
  logic signed [GAIN_W:0]  satGain;
  logic signed [12:0]      offTerm;
  logic signed [19:0]      gainProd;
  logic signed [15:0]      total;

  always_comb
  begin
    sumOff = $signed({userOffset[OFF_W-1], userOffset}) + $signed({factoryOffset[OFF_W-1], factoryOffset});
    sumGain = $signed({userGain[GAIN_W-1], userGain}) + $signed({factoryGain[GAIN_W-1], factoryGain});
    satOff = (sumOff > OFF_SUM_MAX) ? OFF_SUM_MAX : (sumOff < OFF_SUM_MIN) ? OFF_SUM_MIN : sumOff;
    satGain = (sumGain > GAIN_SUM_MAX) ? GAIN_SUM_MAX : (sumGain < GAIN_SUM_MIN) ? GAIN_SUM_MIN : sumGain;
    offTerm = {{7{satOff[OFF_W]}}, satOff} * {{5{OFF_STEP[7]}}, OFF_STEP};
    gainProd = {{6{sampleIn[SMP_W-1]}}, sampleIn} * {{13{satGain[GAIN_W]}}, satGain};
    total = {{2{sampleIn[SMP_W-1]}}, sampleIn} + {{3{offTerm[12]}}, offTerm}
          + {{2{gainProd[19]}}, gainProd[19:GAIN_SHIFT]};
    d = q;
    if (total > SMP_MAX)
      d.outVal = SMP_MAX[SMP_W-1:0];
    else if (total < SMP_MIN)
      d.outVal = SMP_MIN[SMP_W-1:0];
    else
      d.outVal = total[SMP_W-1:0];
  end

  // State register.
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      q <= '0;
    else
      q <= d;
  end

  assign sampleOut = q.outVal;

  AST_OFF_SAT: assert property (@(posedge core_clk) disable iff (sys_rst)
    (sumOff > OFF_SUM_MAX) |-> (satOff == OFF_SUM_MAX))
    else $error("Combined offset trim did not saturate high.");
endmodule // atc_axis_trim
`default_nettype wire

// ### atc_trim_regs.sv
//
// Behaviour
// - The Y offset trim is a 5-bit signed field in bits 4..0, each step moving the Y offset by 15 mg.
// - The Z offset trim is a 5-bit signed field in bits 4..0, each step moving the Z offset by 15 mg.
// - The X gain trim is a 6-bit signed field in bits 5..0, each step changing X sensitivity by 1.56 percent.
// - The Y gain trim is a 6-bit signed field in bits 5..0, each step changing Y sensitivity by 1.56 percent.
// - The Z gain trim is a 6-bit signed field in bits 5..0, each step changing Z sensitivity by 1.56 percent.
// - User and factory trims add inside one shared range and the sum saturates at its ends.
// - The Y offset register has index 0x34 and resets to zero.
// - The gain registers have indexes 0x36, 0x37, 0x38 and reset to zero.
// - The X offset register has index 0x33 and uses the same 5-bit 15 mg format.
`timescale 1ns/1ps
`default_nettype none
module atc_trim_regs
  import atc_pkg::*;
(
  input  wire logic                     core_clk,
  input  wire logic                     sys_rst,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  input  wire logic [3:0]               pstrb,
  output logic [31:0]                   prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic signed [SMP_W-1:0]  xSample,
  input  wire logic signed [SMP_W-1:0]  ySample,
  input  wire logic signed [SMP_W-1:0]  zSample,
  input  wire logic [OFF_W-1:0]         xFactoryOffset,
  input  wire logic [OFF_W-1:0]         yFactoryOffset,
  input  wire logic [OFF_W-1:0]         zFactoryOffset,
  input  wire logic [GAIN_W-1:0]        xFactoryGain,
  input  wire logic [GAIN_W-1:0]        yFactoryGain,
  input  wire logic [GAIN_W-1:0]        zFactoryGain,
  output logic signed [SMP_W-1:0]       xTrimmed,
  output logic signed [SMP_W-1:0]       yTrimmed,
  output logic signed [SMP_W-1:0]       zTrimmed
);
  typedef struct packed {
    logic [OFF_W-1:0]  xOffsetTrim;
    logic [OFF_W-1:0]  yOffsetTrim;
    logic [OFF_W-1:0]  zOffsetTrim;
    logic [GAIN_W-1:0] xGainTrimValue;
    logic [GAIN_W-1:0] yGainTrimValue;
    logic [GAIN_W-1:0] zGainTrimValue;
    logic              ready;
    logic              slvErr;
    logic [31:0]       rdata;
  } atc_regs_t;

  atc_regs_t q, d;
  logic        access;
  logic        complete;
  logic        hit;
  logic [31:0] readVal;

  // Address decode and read multiplexer.
  // reserved bits zero
  always_comb
  begin
    hit = 1'b1;
    readVal = 32'h0000_0000;
    case (paddr)
      ADDR_X_OFF:  readVal = {27'h000_0000, q.xOffsetTrim};
      ADDR_Y_OFF:  readVal = {27'h000_0000, q.yOffsetTrim};
      ADDR_Z_OFF:  readVal = {27'h000_0000, q.zOffsetTrim};
      ADDR_X_GAIN: readVal = {26'h000_0000, q.xGainTrimValue};
      ADDR_Y_GAIN: readVal = {26'h000_0000, q.yGainTrimValue};
      ADDR_Z_GAIN: readVal = {26'h000_0000, q.zGainTrimValue};
      default:     hit = 1'b0;
    endcase
  end

  // The access phase waits one cycle, then the answer stands for one cycle.
  assign access = psel && penable;
  assign complete = access && q.ready;

  // Next-state logic for the bus answer and the trim registers.
  always_comb
  begin
    d = q;
    d.ready = 1'b0;
    d.slvErr = 1'b0;
    if (access && !q.ready)
    begin
      d.ready = 1'b1;
      d.slvErr = !hit;
      d.rdata = pwrite ? 32'h0000_0000 : readVal;
    end
    if (complete && pwrite && pstrb[0])
    begin
      case (paddr)
        ADDR_X_OFF:  d.xOffsetTrim = pwdata[OFF_W-1:0];
        ADDR_Y_OFF:  d.yOffsetTrim = pwdata[OFF_W-1:0];
        ADDR_Z_OFF:  d.zOffsetTrim = pwdata[OFF_W-1:0];
        ADDR_X_GAIN: d.xGainTrimValue = pwdata[GAIN_W-1:0];
        ADDR_Y_GAIN: d.yGainTrimValue = pwdata[GAIN_W-1:0];
        ADDR_Z_GAIN: d.zGainTrimValue = pwdata[GAIN_W-1:0];
        default:     d.rdata = q.rdata;
      endcase
    end
  end

  // State register with reset to no correction.
  // Y offset reset
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      q <= '0;
      q.xOffsetTrim <= OFF_RST;
      q.yOffsetTrim <= OFF_RST;
      q.zOffsetTrim <= OFF_RST;
      q.xGainTrimValue <= GAIN_RST;
      q.yGainTrimValue <= GAIN_RST;
      q.zGainTrimValue <= GAIN_RST;
    end
    else
      q <= d;
  end

  // Bus outputs straight from the state register.
  assign prdata = q.rdata;
  assign pready = q.ready;
  assign pslverr = q.slvErr;

  // Per-axis correction of the measurement path.
  // factory plus user
  atc_axis_trim uXAxis (
    .core_clk      (core_clk),
    .sys_rst       (sys_rst),
    .sampleIn      (xSample),
    .userOffset    (q.xOffsetTrim),
    .userGain      (q.xGainTrimValue),
    .factoryOffset (xFactoryOffset),
    .factoryGain   (xFactoryGain),
    .sampleOut     (xTrimmed)
  );

  atc_axis_trim uYAxis (
    .core_clk      (core_clk),
    .sys_rst       (sys_rst),
    .sampleIn      (ySample),
    .userOffset    (q.yOffsetTrim),
    .userGain      (q.yGainTrimValue),
    .factoryOffset (yFactoryOffset),
    .factoryGain   (yFactoryGain),
    .sampleOut     (yTrimmed)
  );

  atc_axis_trim uZAxis (
    .core_clk      (core_clk),
    .sys_rst       (sys_rst),
    .sampleIn      (zSample),
    .userOffset    (q.zOffsetTrim),
    .userGain      (q.zGainTrimValue),
    .factoryOffset (zFactoryOffset),
    .factoryGain   (zFactoryGain),
    .sampleOut     (zTrimmed)
  );

  // Checks on the register file and its bus answer.
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  AST_X_OFF_WR: assert property (
    complete && pwrite && pstrb[0] && paddr == ADDR_X_OFF
    |=> q.xOffsetTrim == $past(pwdata[OFF_W-1:0]))
    else $error("X offset trim did not take the written value.");

  AST_Y_OFF_WR: assert property (
    complete && pwrite && pstrb[0] && paddr == ADDR_Y_OFF
    |=> q.yOffsetTrim == $past(pwdata[OFF_W-1:0]))
    else $error("Y offset trim did not take the written value.");

  AST_Z_OFF_WR: assert property (
    complete && pwrite && pstrb[0] && paddr == ADDR_Z_OFF
    |=> q.zOffsetTrim == $past(pwdata[OFF_W-1:0]))
    else $error("Z offset trim did not take the written value.");

  AST_X_GAIN_WR: assert property (
    complete && pwrite && pstrb[0] && paddr == ADDR_X_GAIN
    |=> q.xGainTrimValue == $past(pwdata[GAIN_W-1:0]))
    else $error("X gain trim did not take the written value.");

  AST_Y_GAIN_WR: assert property (
    complete && pwrite && pstrb[0] && paddr == ADDR_Y_GAIN
    |=> q.yGainTrimValue == $past(pwdata[GAIN_W-1:0]))
    else $error("Y gain trim did not take the written value.");

  AST_Z_GAIN_WR: assert property (
    complete && pwrite && pstrb[0] && paddr == ADDR_Z_GAIN
    |=> q.zGainTrimValue == $past(pwdata[GAIN_W-1:0]))
    else $error("Z gain trim did not take the written value.");

  AST_Y_OFF_RST: assert property (
    $past(sys_rst) |-> q.yOffsetTrim == OFF_RST && q.xOffsetTrim == OFF_RST)
    else $error("Offset trims not zero after reset.");

  AST_GAIN_RST: assert property (
    $past(sys_rst) |-> (q.xGainTrimValue | q.yGainTrimValue | q.zGainTrimValue) == GAIN_RST)
    else $error("Gain trims not zero after reset.");

  AST_RSVD_ZERO: assert property (
    pready && !pslverr && (paddr == ADDR_X_OFF || paddr == ADDR_Y_OFF || paddr == ADDR_Z_OFF)
    |-> prdata[31:OFF_W] == 27'h000_0000)
    else $error("Reserved offset bits read nonzero.");

  AST_Y_OFF_RDBK: assert property (
    access && !pready && !pwrite && paddr == ADDR_Y_OFF
    |=> pready && prdata[OFF_W-1:0] == $past(q.yOffsetTrim))
    else $error("Y offset readback wrong.");

  AST_ANSWER: assert property (
    access && !pready |=> pready ##1 !pready)
    else $error("Bus answer not one cycle long after one wait.");

  AST_UNMAPPED: assert property (
    access && !pready && !hit |=> pslverr && prdata == 32'h0000_0000)
    else $error("Unmapped address not refused.");

  // Readback of every other trim register in the cycle its answer stands.
  AST_X_OFF_RDBK: assert property (
    access && !pready && !pwrite && paddr == ADDR_X_OFF
    |=> pready && prdata[OFF_W-1:0] == $past(q.xOffsetTrim))
    else $error("X offset readback wrong.");

  AST_Z_OFF_RDBK: assert property (
    access && !pready && !pwrite && paddr == ADDR_Z_OFF
    |=> pready && prdata[OFF_W-1:0] == $past(q.zOffsetTrim))
    else $error("Z offset readback wrong.");

  AST_X_GAIN_RDBK: assert property (
    access && !pready && !pwrite && paddr == ADDR_X_GAIN
    |=> pready && prdata[GAIN_W-1:0] == $past(q.xGainTrimValue))
    else $error("X gain readback wrong.");

  AST_Y_GAIN_RDBK: assert property (
    access && !pready && !pwrite && paddr == ADDR_Y_GAIN
    |=> pready && prdata[GAIN_W-1:0] == $past(q.yGainTrimValue))
    else $error("Y gain readback wrong.");

  AST_Z_GAIN_RDBK: assert property (
    access && !pready && !pwrite && paddr == ADDR_Z_GAIN
    |=> pready && prdata[GAIN_W-1:0] == $past(q.zGainTrimValue))
    else $error("Z gain readback wrong.");

  // The 26 reserved bits of each gain register read as zero.
  AST_RSVD_GAIN_ZERO: assert property (
    pready && !pslverr && (paddr == ADDR_X_GAIN || paddr == ADDR_Y_GAIN || paddr == ADDR_Z_GAIN)
    |-> prdata[31:GAIN_W] == 26'h000_0000)
    else $error("Reserved gain bits read nonzero.");

  // The Z offset trim also starts from no correction.
  AST_Z_OFF_RST: assert property (
    $past(sys_rst) |-> q.zOffsetTrim == OFF_RST)
    else $error("Z offset trim not zero after reset.");

  // A trim changes only at the edge that completes a write to it.
  // Refused writes (strobe off, unmapped address) must leave every trim alone.
  AST_X_OFF_KEEP: assert property (
    !(complete && pwrite && pstrb[0] && paddr == ADDR_X_OFF) |=> $stable(q.xOffsetTrim))
    else $error("X offset trim changed without a write.");

  AST_Y_OFF_KEEP: assert property (
    !(complete && pwrite && pstrb[0] && paddr == ADDR_Y_OFF) |=> $stable(q.yOffsetTrim))
    else $error("Y offset trim changed without a write.");

  AST_Z_OFF_KEEP: assert property (
    !(complete && pwrite && pstrb[0] && paddr == ADDR_Z_OFF) |=> $stable(q.zOffsetTrim))
    else $error("Z offset trim changed without a write.");

  AST_X_GAIN_KEEP: assert property (
    !(complete && pwrite && pstrb[0] && paddr == ADDR_X_GAIN) |=> $stable(q.xGainTrimValue))
    else $error("X gain trim changed without a write.");

  AST_Y_GAIN_KEEP: assert property (
    !(complete && pwrite && pstrb[0] && paddr == ADDR_Y_GAIN) |=> $stable(q.yGainTrimValue))
    else $error("Y gain trim changed without a write.");

  AST_Z_GAIN_KEEP: assert property (
    !(complete && pwrite && pstrb[0] && paddr == ADDR_Z_GAIN) |=> $stable(q.zGainTrimValue))
    else $error("Z gain trim changed without a write.");

  // Bus answer details: error only for holes, zero data on writes, data held between answers.
  // The answer is a single-cycle pulse that never comes without an access.
  AST_MAPPED_OK: assert property (
    access && !pready && hit |=> !pslverr)
    else $error("Mapped address answered with an error.");

  AST_WR_RDATA: assert property (
    access && !pready && pwrite |=> prdata == 32'h0000_0000)
    else $error("Write answer carried nonzero read data.");

  AST_RDATA_HOLD: assert property (
    !(access && !pready) |=> $stable(prdata))
    else $error("Read data changed outside an answer.");

  AST_READY_IDLE: assert property (
    !access |=> !pready)
    else $error("Answer raised without an access.");

  AST_READY_PULSE: assert property (
    pready |=> !pready)
    else $error("Answer stood longer than one cycle.");

  AST_ERR_WITH_READY: assert property (
    pslverr |-> pready)
    else $error("Error flag raised outside an answer.");

  // With no trim at all each axis path passes its sample through one register.
  // This guards the sign extension and scaling against a constant bias.
  AST_X_PASS: assert property (
    (q.xOffsetTrim | xFactoryOffset) == OFF_RST && (q.xGainTrimValue | xFactoryGain) == GAIN_RST
    |=> xTrimmed == $past(xSample))
    else $error("Untrimmed X sample altered.");

  AST_Y_PASS: assert property (
    (q.yOffsetTrim | yFactoryOffset) == OFF_RST && (q.yGainTrimValue | yFactoryGain) == GAIN_RST
    |=> yTrimmed == $past(ySample))
    else $error("Untrimmed Y sample altered.");

  AST_Z_PASS: assert property (
    (q.zOffsetTrim | zFactoryOffset) == OFF_RST && (q.zGainTrimValue | zFactoryGain) == GAIN_RST
    |=> zTrimmed == $past(zSample))
    else $error("Untrimmed Z sample altered.");

  CVR_Y_OFF_WR: cover property (complete && pwrite && paddr == ADDR_Y_OFF);
  CVR_GAIN_RD: cover property (complete && !pwrite && paddr == ADDR_Z_GAIN);
  CVR_UNMAPPED: cover property (complete && pslverr);
  CVR_BACK2BACK: cover property (complete ##1 psel && !penable ##1 access);
  CVR_SAT: cover property (xTrimmed == SMP_MAX[SMP_W-1:0]);
endmodule // atc_trim_regs
`default_nettype wire

// ### axis_trim_calibration_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module axis_trim_calibration_regs_bench
  import atc_pkg::*;
;
  typedef struct packed {logic [7:0] addr; logic [31:0] wdata; logic [31:0] rdata;} atc_row_t;
  logic                    core_clk = 1'b0;
  logic                    sys_rst  = 1'b1;
  logic                    psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]              paddr  = 8'h00;
  logic [31:0]             pwdata = 32'h0;
  logic [3:0]              pstrb  = 4'h0;
  logic [31:0]             prdata, rd;
  logic                    pready, pslverr, er;
  logic signed [SMP_W-1:0] xs = '0, ys = '0, zs = '0, xt, yt, zt;
  logic [OFF_W-1:0]        fo = '0;
  logic [GAIN_W-1:0]       fg = '0;
  int                      n_fail = 0, comparisons = 0;
  logic [7:0]              regs [6] = '{ADDR_X_OFF, ADDR_Y_OFF, ADDR_Z_OFF, ADDR_X_GAIN, ADDR_Y_GAIN, ADDR_Z_GAIN};
  // Each row writes a register and names the value that must read back.
  atc_row_t rows [6] = '{'{ADDR_X_OFF, 32'hffffffff, 32'h1f}, '{ADDR_Y_OFF, 32'h00000010, 32'h10},
                         '{ADDR_Z_OFF, 32'h000000ef, 32'h0f}, '{ADDR_X_GAIN, 32'h000000ff, 32'h3f},
                         '{ADDR_Y_GAIN, 32'h00000020, 32'h20}, '{ADDR_Z_GAIN, 32'hffffffa5, 32'h25}};
  // Sample, user offset, user gain, factory offset, factory gain.
  int vec [7][5] = '{'{1000, 0, 0, 0, 0}, '{100, 15, 0, 15, 0}, '{100, -16, 0, -16, 0}, '{4000, 0, 31, 0, 31},
                     '{8000, 15, 31, 0, 0}, '{-8000, -16, 31, 0, 0}, '{1000, -1, -1, 1, 1}};

  // The clock toggles every half period of 25 ns.
  always #25 core_clk = ~core_clk;

  atc_trim_regs dut (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .xSample(xs), .ySample(ys), .zSample(zs), .xFactoryOffset(fo), .yFactoryOffset(fo), .zFactoryOffset(fo),
    .xFactoryGain(fg), .yFactoryGain(fg), .zFactoryGain(fg), .xTrimmed(xt), .yTrimmed(yt), .zTrimmed(zt));

  // Prints the counts and the verdict, then stops the run.
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // One APB transfer; the request is held until pready is seen at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int k;
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge core_clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1)
    begin
      $display("[FAIL] pready expected 1 seen %b", pready);
      n_fail++;
      conclude();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Compares a bus word.
  task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask

  // Compares a trimmed sample.
  task automatic chk14(input string nm, input logic [SMP_W-1:0] e, input logic [SMP_W-1:0] g);
    comparisons++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask

  // Bench reference for one axis: clamped trim sums, then a clamped sample.
  function automatic logic [SMP_W-1:0] ref14(int s, int uo, int ug, int o, int g);
    int v;
    o = (uo + o > 15) ? 15 : (uo + o < -16) ? -16 : uo + o;
    g = (ug + g > 31) ? 31 : (ug + g < -32) ? -32 : ug + g;
    v = s + o * 16 + ((s * g) >>> 6);
    v = (v > 8191) ? 8191 : (v < -8192) ? -8192 : v;
    return v[SMP_W-1:0];
  endfunction

  // Main sequence: reset values, row loop, then refusals and the trimmed samples.
  initial
  begin
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    foreach (regs[i])
    begin
      apb(1'b0, regs[i], 32'h0, 4'h0);
      chk32("reset value", 32'h0, rd);
    end
    $display("Test reset values done");
    foreach (rows[i])
    begin
      apb(1'b1, rows[i].addr, rows[i].wdata, 4'hf);
      apb(1'b0, rows[i].addr, 32'h0, 4'h0);
      chk32("readback", rows[i].rdata, rd);
      chk32("pslverr", 32'h0, 32'(er));
    end
    $display("Test register rows done");
    apb(1'b1, ADDR_Y_OFF, 32'h05, 4'h0);
    apb(1'b0, ADDR_Y_OFF, 32'h0, 4'h0);
    chk32("strobe off write", 32'h10, rd);
    apb(1'b0, 8'he4, 32'h0, 4'h0);
    chk32("unmapped data", 32'h0, rd);
    chk32("unmapped error", 32'h1, 32'(er));
    apb(1'b1, 8'he4, 32'h1f, 4'hf);
    chk32("unmapped write error", 32'h1, 32'(er));
    apb(1'b0, ADDR_Y_OFF, 32'h0, 4'h0);
    chk32("unmapped write kept", 32'h10, rd);
    $display("Test refusals done");
    foreach (vec[i])
    begin
      for (int r = 0; r < 3; r++)
      begin
        apb(1'b1, regs[r], 32'(vec[i][1]), 4'hf);
        apb(1'b1, regs[r + 3], 32'(vec[i][2]), 4'hf);
      end
      xs <= 14'(vec[i][0]);
      ys <= 14'(-vec[i][0]);
      zs <= 14'(vec[i][0] / 2);
      fo <= 5'(vec[i][3]);
      fg <= 6'(vec[i][4]);
      repeat (3) @(posedge core_clk);
      chk14("x trimmed", ref14(vec[i][0], vec[i][1], vec[i][2], vec[i][3], vec[i][4]), xt);
      chk14("y trimmed", ref14(-vec[i][0], vec[i][1], vec[i][2], vec[i][3], vec[i][4]), yt);
      chk14("z trimmed", ref14(vec[i][0] / 2, vec[i][1], vec[i][2], vec[i][3], vec[i][4]), zt);
    end
    $display("Test trimmed samples done");
    // A second reset in mid-run must clear the trims that the vectors left behind.
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    foreach (regs[i])
    begin
      apb(1'b0, regs[i], 32'h0, 4'h0);
      chk32("value after reset", 32'h0, rd);
    end
    $display("Test reset in run done");
    conclude();
  end
endmodule // axis_trim_calibration_regs_bench
`default_nettype wire
